//--- core/idrx_pkg.sv
// Notes on behaviour
// - pair increment takes 6 T, flags untouched
// - pair increment code 00 ss 0011
// - prefix dd then 23 increments first index
// - prefix fd then 23 increments second index
// - index inc/dec takes 4 then 6 T
// - pair decrement, same selector, flags untouched
// - prefix dd then 2b decrements first index
// - prefix fd then 2b decrements second index
// - opcode 07 rotates accumulator left circular
// - opcode 17 rotates accumulator left through carry
// - opcode 0f rotates accumulator right circular
// - opcode 1f rotates accumulator right through carry
// - accumulator rotates take one 4 T cycle
// - prefix cb then 00000 rrr selects register
// - register rotate copies bit 7, 8 T
// - prefixed rotate sets sign, zero, parity flags
// - cb 06 rotates pointed memory byte, 15 T
package idrx_pkg;
    // opcode bytes
    localparam logic [7:0] OP_PFX_IDX1 = 8'hdd;
    localparam logic [7:0] OP_PFX_IDX2 = 8'hfd;
    localparam logic [7:0] OP_PFX_BIT = 8'hcb;
    localparam logic [7:0] OP_IDX_INC = 8'h23;
    localparam logic [7:0] OP_IDX_DEC = 8'h2b;
    localparam logic [7:0] OP_ACC_LC = 8'h07;
    localparam logic [7:0] OP_ACC_LT = 8'h17;
    localparam logic [7:0] OP_ACC_RC = 8'h0f;
    localparam logic [7:0] OP_ACC_RT = 8'h1f;
    localparam logic [7:0] OP_MEM_LC = 8'h06;
    localparam logic [7:0] OP_NONE = 8'h00;
    // field patterns
    localparam logic [1:0] PAIR_TOP = 2'h0;
    localparam logic [3:0] PAIR_INC_LOW = 4'h3;
    localparam logic [3:0] PAIR_DEC_LOW = 4'hb;
    localparam logic [4:0] PFX_LC_TOP = 5'h00;
    localparam logic [2:0] REG_CODE_MEM = 3'h6;
    // flag bit positions
    localparam int FLAG_S = 7;
    localparam int FLAG_Z = 6;
    localparam int FLAG_H = 4;
    localparam int FLAG_PV = 2;
    localparam int FLAG_N = 1;
    localparam int FLAG_C = 0;
    // register write selectors
    localparam int WSEL_W = 3;
    localparam logic [2:0] WSEL_PAIR1 = 3'h0;
    localparam logic [2:0] WSEL_PAIR2 = 3'h1;
    localparam logic [2:0] WSEL_PTR = 3'h2;
    localparam logic [2:0] WSEL_STACK = 3'h3;
    localparam logic [2:0] WSEL_ACCF = 3'h4;
    localparam logic [2:0] WSEL_IDX1 = 3'h5;
    localparam logic [2:0] WSEL_IDX2 = 3'h6;
    // timing: one T state is a divided enable of the system clock
    localparam int CLK_NS = 10;
    localparam int TSTATE_NS = 40;
    localparam int T_DIV = TSTATE_NS / CLK_NS;
    localparam logic [1:0] DIV_LAST = 2'(T_DIV - 1);
    localparam logic [2:0] T_FETCH_M = 3'h4;
    localparam logic [2:0] T_PAIR_M1 = 3'h6;
    localparam logic [2:0] T_IDX_M2 = 3'h6;
    localparam logic [2:0] T_MEM_RD = 3'h4;
    localparam logic [2:0] T_MEM_WR = 3'h3;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [7:0] RST_BYTE = 8'h00;
    typedef enum logic [2:0] {
        ST_FETCH = 3'b000,
        ST_M1 = 3'b001,
        ST_FETCH2 = 3'b010,
        ST_M2 = 3'b011,
        ST_MRD = 3'b100,
        ST_MWR = 3'b101
    } idrx_st_t;
    typedef enum logic [2:0] {
        ALU_ACC_LC = 3'b000,
        ALU_ACC_LT = 3'b001,
        ALU_ACC_RC = 3'b010,
        ALU_ACC_RT = 3'b011,
        ALU_PFX_LC = 3'b100
    } idrx_alu_t;
endpackage : idrx_pkg

//--- core/idrx_alu_if.sv
`timescale 1ns/1ps
// rotate unit operands and results
interface idrx_alu_if;
    import idrx_pkg::*;
    idrx_alu_t mode;
    logic [7:0] din;
    logic [7:0] flags_in;
    logic [7:0] dout;
    logic [7:0] flags_out;
    modport core (output mode, output din, output flags_in, input dout, input flags_out);
    modport alu (input mode, input din, input flags_in, output dout, output flags_out);
endinterface : idrx_alu_if

//--- core/idrx_rot_alu.sv
`timescale 1ns/1ps
module idrx_rot_alu (
    idrx_alu_if.alu bus
);
    import idrx_pkg::*;

    // one-bit rotates with their flag effects
    always_comb begin
        logic [7:0] r;
        logic [7:0] f;
        r = bus.din;
        f = bus.flags_in;
        case (bus.mode)
            ALU_ACC_LC: begin
                r = {bus.din[6:0], bus.din[7]};
                f[FLAG_C] = bus.din[7];
            end
            ALU_ACC_LT: begin
                r = {bus.din[6:0], bus.flags_in[FLAG_C]};
                f[FLAG_C] = bus.din[7];
            end
            ALU_ACC_RC: begin
                r = {bus.din[0], bus.din[7:1]};
                f[FLAG_C] = bus.din[0];
            end
            ALU_ACC_RT: begin
                r = {bus.flags_in[FLAG_C], bus.din[7:1]};
                f[FLAG_C] = bus.din[0];
            end
            ALU_PFX_LC: begin
                r = {bus.din[6:0], bus.din[7]};
                f[FLAG_C] = bus.din[7];
                f[FLAG_S] = r[7];
                f[FLAG_Z] = (r == 8'h00);
                f[FLAG_PV] = ~^r;
            end
            default: begin
                r = bus.din;
            end
        endcase
        // sign, zero, parity kept for accumulator forms; h and n always cleared
        f[FLAG_H] = 1'b0;
        f[FLAG_N] = 1'b0;
        bus.dout = r;
        bus.flags_out = f;
    end
endmodule : idrx_rot_alu

//--- core/idrx_core.sv
`timescale 1ns/1ps
module idrx_core (
    input wire logic SYS_CLK,
    input wire logic RSTN,
    input wire logic INSTR_VALID,
    input wire logic [7:0] INSTR_BYTE,
    output logic INSTR_READY,
    input wire logic [7:0] MEM_RDATA,
    output logic [15:0] MEM_ADDR,
    output logic MEM_RD,
    output logic MEM_WR,
    output logic [7:0] MEM_WDATA,
    input wire logic REG_WR_EN,
    input wire logic [idrx_pkg::WSEL_W-1:0] REG_WR_SEL,
    input wire logic [15:0] REG_WR_DATA,
    output logic [15:0] REG_PAIR1,
    output logic [15:0] REG_PAIR2,
    output logic [15:0] REG_PTR,
    output logic [15:0] REG_STACK,
    output logic [15:0] REG_IDX1,
    output logic [15:0] REG_IDX2,
    output logic [15:0] REG_ACC_FLAGS,
    output logic DONE,
    output logic ILLEGAL_OP,
    output logic [4:0] TSTATES,
    output logic [2:0] MCYCLES
);
    import idrx_pkg::*;

    typedef struct packed {
        idrx_st_t st;
        logic [1:0] div;
        logic [2:0] tcnt;
        logic [2:0] mlen;
        logic [4:0] tot;
        logic [2:0] mcnt;
        logic [7:0] pfx;
        logic [7:0] op;
        logic [7:0] mdata;
        logic [15:0] pair1;
        logic [15:0] pair2;
        logic [15:0] ptr;
        logic [15:0] stk;
        logic [15:0] idx1;
        logic [15:0] idx2;
        logic [7:0] acc;
        logic [7:0] flg;
        logic ready;
        logic done;
        logic illegal;
        logic mem_rd;
        logic mem_wr;
        logic [4:0] tstates;
        logic [2:0] mcycles;
    } idrx_state_t;

    localparam idrx_state_t S_RESET = '0;

    idrx_state_t s_ff;
    idrx_state_t nxt_s;
    idrx_alu_if alu_bus ();

    idrx_rot_alu u_alu (
        .bus(alu_bus.alu)
    );

    // register pair read by two-bit selector
    function automatic logic [15:0] pair_get(input idrx_state_t st, input logic [1:0] sel);
        case (sel)
            2'h0: pair_get = st.pair1;
            2'h1: pair_get = st.pair2;
            2'h2: pair_get = st.ptr;
            default: pair_get = st.stk;
        endcase
    endfunction : pair_get

    // byte register read by three-bit code
    function automatic logic [7:0] reg8_get(input idrx_state_t st, input logic [2:0] code);
        case (code)
            3'h0: reg8_get = st.pair1[15:8];
            3'h1: reg8_get = st.pair1[7:0];
            3'h2: reg8_get = st.pair2[15:8];
            3'h3: reg8_get = st.pair2[7:0];
            3'h4: reg8_get = st.ptr[15:8];
            3'h5: reg8_get = st.ptr[7:0];
            default: reg8_get = st.acc;
        endcase
    endfunction : reg8_get

    function automatic logic is_pair_op(input logic [7:0] b);
        is_pair_op = (b[7:6] == PAIR_TOP) && (b[3:0] == PAIR_INC_LOW || b[3:0] == PAIR_DEC_LOW);
    endfunction : is_pair_op

    // rotate unit operand selection
    always_comb begin
        alu_bus.flags_in = s_ff.flg;
        if (s_ff.pfx == OP_PFX_BIT) begin
            alu_bus.mode = ALU_PFX_LC;
            if (s_ff.op[2:0] == REG_CODE_MEM) begin
                alu_bus.din = MEM_RDATA;
            end else begin
                alu_bus.din = reg8_get(s_ff, s_ff.op[2:0]);
            end
        end else begin
            alu_bus.din = s_ff.acc;
            case (s_ff.op)
                OP_ACC_LT: alu_bus.mode = ALU_ACC_LT;
                OP_ACC_RC: alu_bus.mode = ALU_ACC_RC;
                OP_ACC_RT: alu_bus.mode = ALU_ACC_RT;
                default: alu_bus.mode = ALU_ACC_LC;
            endcase
        end
    end

    // sequencer: machine cycles counted in T-state enables
    always_comb begin
        logic tick;
        logic take;
        logic fin;
        logic [2:0] tnew;
        logic [4:0] totnew;
        logic [15:0] pv;
        tick = (s_ff.div == DIV_LAST);
        take = s_ff.ready && INSTR_VALID;
        fin = 1'b0;
        tnew = 3'(s_ff.tcnt + 3'h1);
        totnew = 5'(s_ff.tot + 5'h1);
        pv = pair_get(s_ff, s_ff.op[5:4]);
        nxt_s = s_ff;
        nxt_s.done = 1'b0;
        nxt_s.illegal = 1'b0;
        nxt_s.div = tick ? 2'h0 : 2'(s_ff.div + 2'h1);
        case (s_ff.st)
            ST_FETCH: begin
                if (take) begin
                    nxt_s.pfx = OP_NONE;
                    nxt_s.op = INSTR_BYTE;
                    nxt_s.tcnt = 3'h1;
                    nxt_s.tot = 5'h1;
                    nxt_s.mcnt = 3'h1;
                    nxt_s.mlen = is_pair_op(INSTR_BYTE) ? T_PAIR_M1 : T_FETCH_M;
                    nxt_s.st = ST_M1;
                end else if (REG_WR_EN) begin
                    case (REG_WR_SEL)
                        WSEL_PAIR1: nxt_s.pair1 = REG_WR_DATA;
                        WSEL_PAIR2: nxt_s.pair2 = REG_WR_DATA;
                        WSEL_PTR: nxt_s.ptr = REG_WR_DATA;
                        WSEL_STACK: nxt_s.stk = REG_WR_DATA;
                        WSEL_ACCF: {nxt_s.acc, nxt_s.flg} = REG_WR_DATA;
                        WSEL_IDX1: nxt_s.idx1 = REG_WR_DATA;
                        WSEL_IDX2: nxt_s.idx2 = REG_WR_DATA;
                        default: nxt_s.illegal = 1'b1;
                    endcase
                end
            end
            ST_M1: begin
                if (tick) begin
                    nxt_s.tcnt = tnew;
                    nxt_s.tot = totnew;
                    if (tnew == s_ff.mlen) begin
                        if (s_ff.op == OP_PFX_IDX1 || s_ff.op == OP_PFX_IDX2
                            || s_ff.op == OP_PFX_BIT) begin
                            nxt_s.pfx = s_ff.op;
                            nxt_s.st = ST_FETCH2;
                        end else begin
                            fin = 1'b1;
                            if (is_pair_op(s_ff.op)) begin
                                // selector 00/01/10/11, no flag touched
                                if (s_ff.op[3:0] == PAIR_INC_LOW) begin
                                    pv = 16'(pv + 16'h0001);
                                end else begin
                                    pv = 16'(pv - 16'h0001);
                                end
                                case (s_ff.op[5:4])
                                    2'h0: nxt_s.pair1 = pv;
                                    2'h1: nxt_s.pair2 = pv;
                                    2'h2: nxt_s.ptr = pv;
                                    default: nxt_s.stk = pv;
                                endcase
                            end else if (s_ff.op == OP_ACC_LC || s_ff.op == OP_ACC_LT
                                || s_ff.op == OP_ACC_RC || s_ff.op == OP_ACC_RT) begin
                                nxt_s.acc = alu_bus.dout;
                                nxt_s.flg = alu_bus.flags_out;
                            end else begin
                                nxt_s.illegal = 1'b1;
                            end
                        end
                    end
                end
            end
            ST_FETCH2: begin
                if (take) begin
                    nxt_s.op = INSTR_BYTE;
                    nxt_s.tcnt = 3'h1;
                    nxt_s.tot = totnew;
                    nxt_s.mcnt = 3'(s_ff.mcnt + 3'h1);
                    if (s_ff.pfx != OP_PFX_BIT
                        && (INSTR_BYTE == OP_IDX_INC || INSTR_BYTE == OP_IDX_DEC)) begin
                        nxt_s.mlen = T_IDX_M2;
                    end else begin
                        nxt_s.mlen = T_FETCH_M;
                    end
                    nxt_s.st = ST_M2;
                end
            end
            ST_M2: begin
                if (tick) begin
                    nxt_s.tcnt = tnew;
                    nxt_s.tot = totnew;
                    if (tnew == s_ff.mlen) begin
                        if (s_ff.pfx == OP_PFX_BIT && s_ff.op == OP_MEM_LC) begin
                            nxt_s.st = ST_MRD;
                            nxt_s.tcnt = 3'h0;
                            nxt_s.mlen = T_MEM_RD;
                            nxt_s.mcnt = 3'(s_ff.mcnt + 3'h1);
                            nxt_s.mem_rd = 1'b1;
                        end else begin
                            fin = 1'b1;
                            if (s_ff.pfx == OP_PFX_IDX1 && s_ff.op == OP_IDX_INC) begin
                                nxt_s.idx1 = 16'(s_ff.idx1 + 16'h0001);
                            end else if (s_ff.pfx == OP_PFX_IDX2 && s_ff.op == OP_IDX_INC) begin
                                nxt_s.idx2 = 16'(s_ff.idx2 + 16'h0001);
                            end else if (s_ff.pfx == OP_PFX_IDX1 && s_ff.op == OP_IDX_DEC) begin
                                nxt_s.idx1 = 16'(s_ff.idx1 - 16'h0001);
                            end else if (s_ff.pfx == OP_PFX_IDX2 && s_ff.op == OP_IDX_DEC) begin
                                nxt_s.idx2 = 16'(s_ff.idx2 - 16'h0001);
                            end else if (s_ff.pfx == OP_PFX_BIT && s_ff.op[7:3] == PFX_LC_TOP) begin
                                nxt_s.flg = alu_bus.flags_out;
                                case (s_ff.op[2:0])
                                    3'h0: nxt_s.pair1[15:8] = alu_bus.dout;
                                    3'h1: nxt_s.pair1[7:0] = alu_bus.dout;
                                    3'h2: nxt_s.pair2[15:8] = alu_bus.dout;
                                    3'h3: nxt_s.pair2[7:0] = alu_bus.dout;
                                    3'h4: nxt_s.ptr[15:8] = alu_bus.dout;
                                    3'h5: nxt_s.ptr[7:0] = alu_bus.dout;
                                    default: nxt_s.acc = alu_bus.dout;
                                endcase
                            end else begin
                                nxt_s.illegal = 1'b1;
                            end
                        end
                    end
                end
            end
            ST_MRD: begin
                if (tick) begin
                    nxt_s.tcnt = tnew;
                    nxt_s.tot = totnew;
                    if (tnew == s_ff.mlen) begin
                        // memory byte sampled on the last read T state
                        nxt_s.mdata = alu_bus.dout;
                        nxt_s.flg = alu_bus.flags_out;
                        nxt_s.mem_rd = 1'b0;
                        nxt_s.mem_wr = 1'b1;
                        nxt_s.st = ST_MWR;
                        nxt_s.tcnt = 3'h0;
                        nxt_s.mlen = T_MEM_WR;
                        nxt_s.mcnt = 3'(s_ff.mcnt + 3'h1);
                    end
                end
            end
            ST_MWR: begin
                if (tick) begin
                    nxt_s.tcnt = tnew;
                    nxt_s.tot = totnew;
                    if (tnew == s_ff.mlen) begin
                        nxt_s.mem_wr = 1'b0;
                        fin = 1'b1;
                    end
                end
            end
            default: begin
                nxt_s = S_RESET;
            end
        endcase
        if (fin) begin
            nxt_s.st = ST_FETCH;
            nxt_s.done = 1'b1;
            nxt_s.tstates = nxt_s.tot;
            nxt_s.mcycles = nxt_s.mcnt;
        end
        // ready only on a T-state enable while waiting for a byte
        nxt_s.ready = (nxt_s.st == ST_FETCH || nxt_s.st == ST_FETCH2) && (nxt_s.div == DIV_LAST);
    end

    // state register
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            s_ff <= S_RESET;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // outputs straight from the state register
    assign INSTR_READY = s_ff.ready;
    assign MEM_ADDR = s_ff.ptr;
    assign MEM_RD = s_ff.mem_rd;
    assign MEM_WR = s_ff.mem_wr;
    assign MEM_WDATA = s_ff.mdata;
    assign REG_PAIR1 = s_ff.pair1;
    assign REG_PAIR2 = s_ff.pair2;
    assign REG_PTR = s_ff.ptr;
    assign REG_STACK = s_ff.stk;
    assign REG_IDX1 = s_ff.idx1;
    assign REG_IDX2 = s_ff.idx2;
    assign REG_ACC_FLAGS = {s_ff.acc, s_ff.flg};
    assign DONE = s_ff.done;
    assign ILLEGAL_OP = s_ff.illegal;
    assign TSTATES = s_ff.tstates;
    assign MCYCLES = s_ff.mcycles;

    // previous values for the checks below
    logic [7:0] acc_prev;
    logic [7:0] flg_prev;
    always_ff @(posedge SYS_CLK) begin
        acc_prev <= s_ff.acc;
        flg_prev <= s_ff.flg;
    end

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);

    a_pair_inc_time: assert property (DONE && s_ff.pfx == OP_NONE && s_ff.op == 8'h23
        |-> TSTATES == 5'd6 && MCYCLES == 3'd1 && $stable(s_ff.flg))
        else $error("pair increment timing or flags wrong");
    a_pair_dec_val: assert property (DONE && s_ff.pfx == OP_NONE && s_ff.op == 8'h0b
        |-> s_ff.pair1 == 16'($past(s_ff.pair1) - 16'h0001) && $stable(s_ff.flg))
        else $error("pair decrement wrong");
    a_idx1_inc_val: assert property (DONE && s_ff.pfx == OP_PFX_IDX1 && s_ff.op == OP_IDX_INC
        |-> s_ff.idx1 == 16'($past(s_ff.idx1) + 16'h0001) && $stable(s_ff.flg))
        else $error("first index increment wrong");
    a_idx2_inc_val: assert property (DONE && s_ff.pfx == OP_PFX_IDX2 && s_ff.op == OP_IDX_INC
        |-> s_ff.idx2 == 16'($past(s_ff.idx2) + 16'h0001))
        else $error("second index increment wrong");
    a_idx_timing: assert property (DONE && s_ff.pfx != OP_PFX_BIT && s_ff.pfx != OP_NONE
        && !ILLEGAL_OP |-> TSTATES == 5'd10 && MCYCLES == 3'd2)
        else $error("index op timing wrong");
    a_idx1_dec_val: assert property (DONE && s_ff.pfx == OP_PFX_IDX1 && s_ff.op == OP_IDX_DEC
        |-> s_ff.idx1 == 16'($past(s_ff.idx1) - 16'h0001))
        else $error("first index decrement wrong");
    a_idx2_dec_val: assert property (DONE && s_ff.pfx == OP_PFX_IDX2 && s_ff.op == OP_IDX_DEC
        |-> s_ff.idx2 == 16'($past(s_ff.idx2) - 16'h0001) && $stable(s_ff.flg))
        else $error("second index decrement wrong");
    a_acc_lc_val: assert property (DONE && s_ff.pfx == OP_NONE && s_ff.op == OP_ACC_LC
        |-> s_ff.acc == {acc_prev[6:0], acc_prev[7]} && s_ff.flg[FLAG_C] == acc_prev[7]
        && s_ff.flg[7:6] == flg_prev[7:6] && !s_ff.flg[FLAG_H] && !s_ff.flg[FLAG_N]
        && TSTATES == 5'd4)
        else $error("accumulator left circular wrong");
    a_acc_lt_val: assert property (DONE && s_ff.pfx == OP_NONE && s_ff.op == OP_ACC_LT
        |-> s_ff.acc == {acc_prev[6:0], flg_prev[FLAG_C]} && s_ff.flg[FLAG_C] == acc_prev[7]
        && s_ff.flg[FLAG_PV] == flg_prev[FLAG_PV])
        else $error("accumulator left through carry wrong");
    a_acc_rc_val: assert property (DONE && s_ff.pfx == OP_NONE && s_ff.op == OP_ACC_RC
        |-> s_ff.acc == {acc_prev[0], acc_prev[7:1]} && s_ff.flg[FLAG_C] == acc_prev[0])
        else $error("accumulator right circular wrong");
    a_acc_rt_val: assert property (DONE && s_ff.pfx == OP_NONE && s_ff.op == OP_ACC_RT
        |-> s_ff.acc == {flg_prev[FLAG_C], acc_prev[7:1]} && s_ff.flg[FLAG_C] == acc_prev[0]
        && MCYCLES == 3'd1)
        else $error("accumulator right through carry wrong");
    a_pfx_acc_rot: assert property (DONE && s_ff.pfx == OP_PFX_BIT && s_ff.op == 8'h07
        |-> s_ff.acc == {acc_prev[6:0], acc_prev[7]} && s_ff.flg[FLAG_Z] == (s_ff.acc == 8'h00)
        && s_ff.flg[FLAG_S] == s_ff.acc[7] && s_ff.flg[FLAG_PV] == ~^s_ff.acc
        && TSTATES == 5'd8 && MCYCLES == 3'd2)
        else $error("prefixed register rotate wrong");
    a_mem_rot_seq: assert property (DONE && s_ff.pfx == OP_PFX_BIT && s_ff.op == OP_MEM_LC
        |-> TSTATES == 5'd15 && MCYCLES == 3'd4 && $past(MEM_WR))
        else $error("memory rotate sequence wrong");
    a_mem_wr_len: assert property ($rose(MEM_WR) |-> MEM_WR [*8] ##1 MEM_WR [*4] ##1 !MEM_WR)
        else $error("memory write length wrong");

    c_mem_rot: cover property (DONE && s_ff.pfx == OP_PFX_BIT && s_ff.op == OP_MEM_LC);
    c_idx_op: cover property (DONE && s_ff.pfx == OP_PFX_IDX2 && !ILLEGAL_OP);
    c_acc_rot: cover property (DONE && s_ff.op == OP_ACC_LT);
    c_pair_op: cover property (DONE && s_ff.pfx == OP_NONE && s_ff.op == 8'h3b);
endmodule : idrx_core

//--- bench/idrx_mem_model.sv
`timescale 1ns/1ps
// byte memory on the far bus; only the low address nibble decodes
module idrx_mem_model (
    input wire logic sys_clk,
    input wire logic [15:0] addr,
    input wire logic rd,
    input wire logic wr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] cells [16];
    logic [7:0] last_ff = 8'h00;
    // data only while the read strobe stands, inverted leftovers otherwise
    always_comb rdata = rd ? cells[addr[3:0]] : ~last_ff;
    // write back on each clock of the write strobe
    always @(posedge sys_clk) begin
        if (rd) last_ff <= cells[addr[3:0]];
        if (wr) cells[addr[3:0]] <= wdata;
    end
endmodule : idrx_mem_model

//--- bench/testbench.sv
`timescale 1ns/1ps
module testbench;
    import idrx_pkg::*;
    logic SYS_CLK = 1'b0, RSTN = 1'b0, INSTR_VALID = 1'b0, REG_WR_EN = 1'b0;
    logic [7:0] INSTR_BYTE = 8'h00, MEM_RDATA, MEM_WDATA, v, f;
    logic [2:0] REG_WR_SEL = 3'h0, MCYCLES;
    logic [15:0] REG_WR_DATA = 16'h0000, MEM_ADDR, REG_PAIR1, REG_PAIR2, REG_PTR;
    logic [15:0] REG_STACK, REG_IDX1, REG_IDX2, REG_ACC_FLAGS, pr [7];
    logic INSTR_READY, MEM_RD, MEM_WR, DONE, ILLEGAL_OP;
    logic [4:0] TSTATES;
    int errors = 0, compares = 0, cycles = 0;
    logic [7:0] aop [4] = '{8'h07, 8'h17, 8'h0f, 8'h1f};
    logic [7:0] ain [4] = '{8'h88, 8'h76, 8'h11, 8'he1};
    logic [7:0] aout [4] = '{8'h11, 8'hed, 8'h88, 8'h70};
    logic [7:0] ex [8] = '{8'h80, 8'h00, 8'hc3, 8'h41, 8'hff, 8'h88, 8'h00, 8'h7f};
    idrx_core dut (.SYS_CLK, .RSTN, .INSTR_VALID, .INSTR_BYTE, .INSTR_READY, .MEM_RDATA,
        .MEM_ADDR, .MEM_RD, .MEM_WR, .MEM_WDATA, .REG_WR_EN, .REG_WR_SEL, .REG_WR_DATA,
        .REG_PAIR1, .REG_PAIR2, .REG_PTR, .REG_STACK, .REG_IDX1, .REG_IDX2, .REG_ACC_FLAGS,
        .DONE, .ILLEGAL_OP, .TSTATES, .MCYCLES);
    idrx_mem_model mem (.sys_clk(SYS_CLK), .addr(MEM_ADDR), .rd(MEM_RD), .wr(MEM_WR),
        .wdata(MEM_WDATA), .rdata(MEM_RDATA));
    // readback indexed by write selector
    always_comb pr = '{REG_PAIR1, REG_PAIR2, REG_PTR, REG_STACK, REG_ACC_FLAGS, REG_IDX1, REG_IDX2};
    initial forever #5 SYS_CLK = ~SYS_CLK;
    // hang guard
    always @(posedge SYS_CLK) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            give_verdict();
        end
    end
    task give_verdict;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict
    task chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [2:0] sel, input logic [15:0] d);
        REG_WR_EN = 1'b1;
        REG_WR_SEL = sel;
        REG_WR_DATA = d;
        @(posedge SYS_CLK) #1;
        REG_WR_EN = 1'b0;
        @(posedge SYS_CLK) #1;
    endtask : wr
    // hold the byte until a ready cycle has passed its edge
    task send(input logic [7:0] b);
        INSTR_VALID = 1'b1;
        INSTR_BYTE = b;
        while (INSTR_READY !== 1'b1) @(posedge SYS_CLK) #1;
        @(posedge SYS_CLK) #1;
    endtask : send
    // tm packs machine cycles over T states
    task run(input logic [7:0] b1, input logic [7:0] b2, input bit two, input logic [7:0] tm);
        send(b1);
        if (two) send(b2);
        INSTR_VALID = 1'b0;
        while (DONE !== 1'b1) @(posedge SYS_CLK) #1;
        chk({8'h00, MCYCLES, TSTATES}, {8'h00, tm});
    endtask : run
    initial begin
        repeat (3) @(posedge SYS_CLK);
        #1 RSTN = 1'b1;
        wr(WSEL_ACCF, 16'h55ff);
        for (int s = 0; s < 4; s++) begin
            wr(3'(s), 16'hffff);
            run({2'h0, 2'(s), 4'h3}, 8'h00, 0, 8'h26);
            chk(pr[s], 16'h0000);
            run({2'h0, 2'(s), 4'hb}, 8'h00, 0, 8'h26);
            chk(pr[s], 16'hffff);
            chk(REG_ACC_FLAGS, 16'h55ff);
        end
        for (int p = 0; p < 2; p++) begin
            wr(3'(5 + p), 16'h33ff);
            run(p ? OP_PFX_IDX2 : OP_PFX_IDX1, OP_IDX_INC, 1, 8'h4a);
            chk(pr[5 + p], 16'h3400);
            run(p ? OP_PFX_IDX2 : OP_PFX_IDX1, OP_IDX_DEC, 1, 8'h4a);
            chk(pr[5 + p], 16'h33ff);
            chk(REG_ACC_FLAGS, 16'h55ff);
        end
        for (int i = 0; i < 4; i++) begin
            wr(WSEL_ACCF, {ain[i], 8'hd6 | 8'(i == 1)});
            run(aop[i], 8'h00, 0, 8'h24);
            chk(REG_ACC_FLAGS, {aout[i], 8'hc4 | 8'(i != 1)});
        end
        wr(WSEL_PAIR1, {ex[0], ex[1]});
        wr(WSEL_PAIR2, {ex[2], ex[3]});
        wr(WSEL_PTR, {ex[4], ex[5]});
        wr(WSEL_ACCF, {ex[7], 8'h12});
        for (int r = 0; r < 8; r++) begin
            if (r == 6) continue;
            v = {ex[r][6:0], ex[r][7]};
            f = {v[7], v == 8'h00, 3'h0, ~^v, 1'b0, ex[r][7]};
            ex[r] = v;
            run(OP_PFX_BIT, {5'h00, 3'(r)}, 1, 8'h48);
            chk(REG_PAIR1, {ex[0], ex[1]});
            chk(REG_PAIR2, {ex[2], ex[3]});
            chk(REG_PTR, {ex[4], ex[5]});
            chk(REG_ACC_FLAGS, {ex[7], f});
        end
        wr(WSEL_PTR, 16'h2828);
        wr(WSEL_ACCF, 16'h0012);
        mem.cells[8] = 8'h88;
        run(OP_PFX_BIT, OP_MEM_LC, 1, 8'h8f);
        chk({15'h0000, ILLEGAL_OP}, 16'h0000);
        chk({8'h00, mem.cells[8]}, 16'h0011);
        chk(REG_ACC_FLAGS, 16'h0005);
        // byte 00 is neither pair code: a 4 T no-op flagged as unsupported
        run(8'h00, 8'h00, 0, 8'h24);
        chk({15'h0000, ILLEGAL_OP}, 16'h0001);
        chk(REG_ACC_FLAGS, 16'h0005);
        give_verdict();
    end
endmodule : testbench
